// *** common/tmr_pkg.sv ***
// constants, types and field layout of the 8-bit compare timer
// Notes on behaviour
// - force strobe in non-PWM modes acts as an immediate compare match on the output
// - forced match sets no flag, raises no interrupt, never clears the counter
// - force strobe reads zero; software writes it zero in PWM modes
// - mode 00 normal, 01 phase-correct, 10 clear-on-match to compare, 11 fast
// - compare update immediate, at top or at bottom; overflow at MAX or BOTTOM
// - nonzero output mode overrides the port; direction bit enables the driver
// - non-PWM output modes: disconnect, toggle, clear, set on match
// - fast PWM: 10 clear on match set at bottom; 11 inverse; 01 reserved
// - phase-correct: 10 clear on up match, set on down match; 11 inverse
// - PWM with compare equal to top and upper mode bit: act at top instead
// - clock select: stop, undivided, then divide by 8,32,64,128,256,1024
// - counter write blocks compare match on the next timer clock
// - compare register compared continuously with counter; equality is a match
// - irq request when enable, flag and global enable are all set
// - compare flag sets on match; cleared by vector or writing one
// - overflow flag sets on overflow or PWM bottom turn; cleared likewise
// - external clock enable with async opens input buffer; crystal runs under async without it
// - async select picks I/O clock or oscillator pin as timer source
// - async writes set update-busy until value reaches its destination
// - counter reads live value; compare and control read temporary copies
// - prescaler reset bit self-clears, lingers in async, holds under sync hold
// - async written value latches after two rising oscillator edges
// - async flag synchronisation takes three processor cycles plus one timer cycle
package tmr_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_MODE_CONTROL   = 8'h00;
  localparam logic [7:0] OFF_COUNT_VALUE    = 8'h04;
  localparam logic [7:0] OFF_MATCH_VALUE    = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK       = 8'h0c;
  localparam logic [7:0] OFF_IRQ_FLAGS      = 8'h10;
  localparam logic [7:0] OFF_ASYNC_STATUS   = 8'h14;
  localparam logic [7:0] OFF_SHARED_CONTROL = 8'h18;

  // ----------------------------------------------------------------
  // field positions and values
  // ----------------------------------------------------------------
  localparam int unsigned BIT_CMP_IRQ       = 1;
  localparam int unsigned BIT_OVF_IRQ       = 0;
  localparam int unsigned BIT_EXT_CLK_EN    = 4;
  localparam int unsigned BIT_ASYNC_SEL     = 3;
  localparam int unsigned BIT_SYNC_HOLD     = 7;
  localparam int unsigned BIT_PRESCALE_RST  = 1;
  localparam int unsigned IDX_CTRL          = 0;
  localparam int unsigned IDX_MATCH         = 1;
  localparam int unsigned IDX_COUNT         = 2;
  localparam logic [7:0]  CNT_MAX           = 8'hff;
  localparam logic [7:0]  CNT_BOTTOM        = 8'h00;
  localparam logic [7:0]  REG_RESET         = 8'h00;
  localparam int unsigned FLAG_SYNC_CYCLES  = 3;
  localparam int unsigned PRE_W             = 10;

  // prescaler tap masks per clock select value
  localparam logic [7:0][PRE_W-1:0] PRE_MASK = {
    10'h3ff, 10'h0ff, 10'h07f, 10'h03f, 10'h01f, 10'h007, 10'h000, 10'h000};

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    WGM_NORMAL = 2'b00,
    WGM_PC_PWM = 2'b01,
    WGM_CTC    = 2'b10,
    WGM_FAST   = 2'b11
  } tmr_wgm_t;

  typedef enum logic [1:0] {
    XFER_IDLE  = 2'b00,
    XFER_WAIT  = 2'b01,
    XFER_EDGE1 = 2'b11
  } tmr_xfer_t;

  // mode_control_register layout, bit 7 down to bit 0
  typedef struct packed {
    logic       force_compare_strobe;
    logic       wgm_lo;
    logic [1:0] compare_output_mode_field;
    logic       wgm_hi;
    logic [2:0] clock_select_field;
  } tmr_ctrl_t;

endpackage

// *** logic/tmr_timer.sv ***
// 8-bit timer with one compare channel and a classic wishbone slave
//
// The address map and register access over Wishbone were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module tmr_timer #(
  parameter int unsigned FLAG_SYNC = tmr_pkg::FLAG_SYNC_CYCLES
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // processor side
  input  wire logic        global_irq_enable_i,
  input  wire logic        compare_vector_ack_i,
  input  wire logic        overflow_vector_ack_i,
  output logic             compare_irq_o,
  output logic             overflow_irq_o,
  // pins
  input  wire logic        oscillator_input_pin_i,
  input  wire logic        port_dir_i,
  output logic             compare_output_pin_o,
  output logic             compare_output_override_o,
  output logic             compare_output_oe_o,
  output logic             ext_clock_buffer_en_o,
  output logic             crystal_osc_run_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  tmr_pkg::tmr_ctrl_t ctrl_q;
  tmr_pkg::tmr_ctrl_t ctrl_tmp_q;
  logic [7:0]         cnt_q;
  logic [7:0]         cnt_tmp_q;
  logic [7:0]         ocr_q;
  logic [7:0]         ocr_tmp_q;
  logic [7:0]         ocr_buf_q;
  logic [1:0]         mask_q;
  logic [1:0]         flags_q;
  logic               async_sel_q;
  logic               ext_clk_q;
  logic               sync_hold_q;
  logic               psr_q;
  logic               osc_prev_q;
  logic               down_q;
  logic               block_q;
  logic               oc_q;
  logic               ack_q;
  logic [tmr_pkg::PRE_W-1:0] pre_q;
  logic [FLAG_SYNC-1:0][1:0] fsync_q;
  tmr_pkg::tmr_xfer_t        xfer_q [3];

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic       acc;
  logic       wr;
  logic       wr_shared;
  logic       wr_mask;
  logic       wr_flags;
  logic       wr_status;
  logic [2:0] wr_vec;
  logic [2:0] apply_vec;
  logic [2:0] busy;
  logic [7:0] wd;

  assign acc       = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr        = acc && wb_we_i && wb_sel_i[0];
  assign wd        = wb_dat_i[7:0];
  assign wr_shared = wr && (wb_adr_i == tmr_pkg::OFF_SHARED_CONTROL);
  assign wr_mask   = wr && (wb_adr_i == tmr_pkg::OFF_IRQ_MASK);
  assign wr_flags  = wr && (wb_adr_i == tmr_pkg::OFF_IRQ_FLAGS);
  assign wr_status = wr && (wb_adr_i == tmr_pkg::OFF_ASYNC_STATUS);
  assign wr_vec[tmr_pkg::IDX_CTRL]  = wr && (wb_adr_i == tmr_pkg::OFF_MODE_CONTROL);
  assign wr_vec[tmr_pkg::IDX_MATCH] = wr && (wb_adr_i == tmr_pkg::OFF_MATCH_VALUE);
  assign wr_vec[tmr_pkg::IDX_COUNT] = wr && (wb_adr_i == tmr_pkg::OFF_COUNT_VALUE);
  assign wb_ack_o  = ack_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= acc;
    end
  end

  // ----------------------------------------------------------------
  // timer source and prescaler
  // ----------------------------------------------------------------
  logic osc_rise;
  logic src_tick;
  logic tick;

  assign osc_rise = oscillator_input_pin_i && !osc_prev_q;
  assign src_tick = async_sel_q ? osc_rise : 1'b1;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_prev_q <= 1'b0;
    end else begin
      osc_prev_q <= oscillator_input_pin_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_q <= '0;
    end else if (psr_q) begin
      pre_q <= '0;
    end else if (src_tick) begin
      pre_q <= pre_q + 1'b1;
    end
  end

  always_comb begin
    case (ctrl_q.clock_select_field)
      3'h0:    tick = 1'b0;
      3'h1:    tick = src_tick;
      default: tick = src_tick && !psr_q &&
                      ((pre_q & tmr_pkg::PRE_MASK[ctrl_q.clock_select_field]) ==
                       tmr_pkg::PRE_MASK[ctrl_q.clock_select_field]);
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      psr_q       <= 1'b0;
      sync_hold_q <= 1'b0;
    end else begin
      if (wr_shared) begin
        sync_hold_q <= wd[tmr_pkg::BIT_SYNC_HOLD];
      end
      if (wr_shared && wd[tmr_pkg::BIT_PRESCALE_RST]) begin
        psr_q <= 1'b1;
      end else if (psr_q && !sync_hold_q && (!async_sel_q || src_tick)) begin
        psr_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // async status and write transfer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      async_sel_q <= 1'b0;
      ext_clk_q   <= 1'b0;
    end else if (wr_status) begin
      async_sel_q <= wd[tmr_pkg::BIT_ASYNC_SEL];
      ext_clk_q   <= wd[tmr_pkg::BIT_EXT_CLK_EN];
    end
  end

  assign ext_clock_buffer_en_o = ext_clk_q && async_sel_q;
  assign crystal_osc_run_o     = async_sel_q && !ext_clk_q;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_xfer
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          xfer_q[gi] <= tmr_pkg::XFER_IDLE;
        end else if (wr_vec[gi] && async_sel_q) begin
          xfer_q[gi] <= tmr_pkg::XFER_WAIT;
        end else begin
          case (xfer_q[gi])
            tmr_pkg::XFER_IDLE:  xfer_q[gi] <= tmr_pkg::XFER_IDLE;
            tmr_pkg::XFER_WAIT:  if (osc_rise) xfer_q[gi] <= tmr_pkg::XFER_EDGE1;
            tmr_pkg::XFER_EDGE1: if (osc_rise) xfer_q[gi] <= tmr_pkg::XFER_IDLE;
            default:             xfer_q[gi] <= tmr_pkg::XFER_IDLE;
          endcase
        end
      end
      assign busy[gi]      = (xfer_q[gi] != tmr_pkg::XFER_IDLE);
      assign apply_vec[gi] = async_sel_q ?
                             (xfer_q[gi] == tmr_pkg::XFER_EDGE1 && osc_rise && !wr_vec[gi]) :
                             wr_vec[gi];
    end
  endgenerate

  // temporary copies; the control and compare copies are read back by software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_tmp_q <= tmr_pkg::tmr_ctrl_t'(tmr_pkg::REG_RESET);
      ocr_tmp_q  <= tmr_pkg::REG_RESET;
      cnt_tmp_q  <= tmr_pkg::REG_RESET;
    end else begin
      if (wr_vec[tmr_pkg::IDX_CTRL]) begin
        ctrl_tmp_q <= tmr_pkg::tmr_ctrl_t'(wd);
      end
      if (wr_vec[tmr_pkg::IDX_MATCH]) begin
        ocr_tmp_q <= wd;
      end
      if (wr_vec[tmr_pkg::IDX_COUNT]) begin
        cnt_tmp_q <= wd;
      end
    end
  end

  tmr_pkg::tmr_ctrl_t ctrl_new;
  logic [7:0]         ocr_new;
  logic [7:0]         cnt_new;
  assign ctrl_new = async_sel_q ? ctrl_tmp_q : tmr_pkg::tmr_ctrl_t'(wd);
  assign ocr_new  = async_sel_q ? ocr_tmp_q : wd;
  assign cnt_new  = async_sel_q ? cnt_tmp_q : wd;

  // ----------------------------------------------------------------
  // destination control and compare registers
  // ----------------------------------------------------------------
  logic force_evt;
  logic is_pwm;
  logic is_fast;
  logic is_pc;
  logic is_ctc;
  logic [7:0] top;
  logic [7:0] cmp_val;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= tmr_pkg::tmr_ctrl_t'(tmr_pkg::REG_RESET);
    end else if (apply_vec[tmr_pkg::IDX_CTRL]) begin
      ctrl_q <= ctrl_new;
      ctrl_q.force_compare_strobe <= 1'b0;
    end
  end

  assign is_pwm  = ctrl_q.wgm_lo;
  assign is_fast = ({ctrl_q.wgm_hi, ctrl_q.wgm_lo} == tmr_pkg::WGM_FAST);
  assign is_pc   = ({ctrl_q.wgm_hi, ctrl_q.wgm_lo} == tmr_pkg::WGM_PC_PWM);
  assign is_ctc  = ({ctrl_q.wgm_hi, ctrl_q.wgm_lo} == tmr_pkg::WGM_CTC);
  assign top     = is_ctc ? ocr_q : tmr_pkg::CNT_MAX;
  assign cmp_val = is_pwm ? ocr_buf_q : ocr_q;
  assign force_evt = apply_vec[tmr_pkg::IDX_CTRL] && ctrl_new.force_compare_strobe &&
                     !ctrl_new.wgm_lo;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ocr_q     <= tmr_pkg::REG_RESET;
      ocr_buf_q <= tmr_pkg::REG_RESET;
    end else begin
      if (apply_vec[tmr_pkg::IDX_MATCH]) begin
        ocr_q <= ocr_new;
      end
      if (!is_pwm) begin
        ocr_buf_q <= ocr_q;
      end else if (tick && cnt_q == tmr_pkg::CNT_MAX && (is_fast || !down_q)) begin
        ocr_buf_q <= ocr_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  logic cmp_evt;
  logic ovf_evt;
  logic at_top;

  assign at_top  = (cnt_q == top);
  assign cmp_evt = tick && !block_q && (cnt_q == cmp_val);
  assign ovf_evt = tick && (is_pc ? (down_q && cnt_q == tmr_pkg::CNT_BOTTOM) :
                                    (cnt_q == tmr_pkg::CNT_MAX));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q   <= tmr_pkg::REG_RESET;
      down_q  <= 1'b0;
      block_q <= 1'b0;
    end else if (apply_vec[tmr_pkg::IDX_COUNT]) begin
      cnt_q   <= cnt_new;
      block_q <= 1'b1;
    end else if (tick) begin
      block_q <= 1'b0;
      if (is_pc) begin
        if (!down_q && cnt_q == tmr_pkg::CNT_MAX) begin
          down_q <= 1'b1;
          cnt_q  <= cnt_q - 8'h01;
        end else if (down_q && cnt_q == tmr_pkg::CNT_BOTTOM) begin
          down_q <= 1'b0;
          cnt_q  <= cnt_q + 8'h01;
        end else begin
          cnt_q  <= down_q ? cnt_q - 8'h01 : cnt_q + 8'h01;
        end
      end else begin
        down_q <= 1'b0;
        cnt_q  <= at_top ? tmr_pkg::CNT_BOTTOM : cnt_q + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // waveform output
  // ----------------------------------------------------------------
  logic [1:0] com;
  logic       top_special;
  logic       pwm_match;

  assign com         = ctrl_q.compare_output_mode_field;
  assign top_special = is_pwm && com[1] && (cmp_val == tmr_pkg::CNT_MAX);
  assign pwm_match   = top_special ? (tick && cnt_q == tmr_pkg::CNT_MAX) : cmp_evt;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oc_q <= 1'b0;
    end else if (force_evt) begin
      case (ctrl_new.compare_output_mode_field)
        2'b01:   oc_q <= !oc_q;
        2'b10:   oc_q <= 1'b0;
        2'b11:   oc_q <= 1'b1;
        default: oc_q <= oc_q;
      endcase
    end else if (!is_pwm) begin
      if (cmp_evt) begin
        case (com)
          2'b01:   oc_q <= !oc_q;
          2'b10:   oc_q <= 1'b0;
          2'b11:   oc_q <= 1'b1;
          default: oc_q <= oc_q;
        endcase
      end
    end else if (com[1]) begin
      if (is_fast) begin
        if (pwm_match) begin
          oc_q <= com[0];
        end else if (tick && cnt_q == tmr_pkg::CNT_MAX) begin
          oc_q <= !com[0];
        end
      end else if (pwm_match) begin
        oc_q <= (down_q && !top_special) ? !com[0] : com[0];
      end
    end
  end

  assign compare_output_pin_o      = oc_q;
  assign compare_output_override_o = |com;
  assign compare_output_oe_o       = (|com) && port_dir_i;

  // ----------------------------------------------------------------
  // flags and interrupt requests
  // ----------------------------------------------------------------
  logic [1:0] evt;
  logic [1:0] set_vec;
  logic [1:0] clr_vec;

  assign evt     = {cmp_evt, ovf_evt};
  assign set_vec = async_sel_q ? fsync_q[FLAG_SYNC-1] : evt;
  assign clr_vec = ({2{wr_flags}} & wd[1:0]) |
                   {compare_vector_ack_i, overflow_vector_ack_i};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fsync_q <= '0;
    end else begin
      fsync_q <= {fsync_q[FLAG_SYNC-2:0], evt};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_q <= 2'b00;
    end else begin
      flags_q <= (flags_q & ~clr_vec) | set_vec;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_q <= 2'b00;
    end else if (wr_mask) begin
      mask_q <= wd[1:0];
    end
  end

  assign compare_irq_o  = global_irq_enable_i && mask_q[tmr_pkg::BIT_CMP_IRQ] &&
                          flags_q[tmr_pkg::BIT_CMP_IRQ];
  assign overflow_irq_o = global_irq_enable_i && mask_q[tmr_pkg::BIT_OVF_IRQ] &&
                          flags_q[tmr_pkg::BIT_OVF_IRQ];

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [7:0] rd;

  always_comb begin
    case (wb_adr_i)
      tmr_pkg::OFF_MODE_CONTROL:   rd = {1'b0, ctrl_tmp_q[6:0]};
      tmr_pkg::OFF_COUNT_VALUE:    rd = cnt_q;
      tmr_pkg::OFF_MATCH_VALUE:    rd = ocr_tmp_q;
      tmr_pkg::OFF_IRQ_MASK:       rd = {6'h00, mask_q};
      tmr_pkg::OFF_IRQ_FLAGS:      rd = {6'h00, flags_q};
      tmr_pkg::OFF_ASYNC_STATUS:   rd = {3'h0, ext_clk_q, async_sel_q, busy};
      tmr_pkg::OFF_SHARED_CONTROL: rd = {sync_hold_q, 5'h00, psr_q, 1'b0};
      default:                     rd = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (acc && !wb_we_i) begin
      wb_dat_o <= {24'h00_0000, rd};
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_force_reads_zero: assert property (
    (wb_ack_o && !wb_we_i && wb_adr_i == tmr_pkg::OFF_MODE_CONTROL) |-> !wb_dat_o[7])
    else $error("force strobe read back as one");

  a_force_no_flag: assert property (
    (!async_sel_q && force_evt && !cmp_evt && !flags_q[1]) |=> !flags_q[1])
    else $error("forced match set the compare flag");

  a_cmp_flag_sync: assert property (
    (!async_sel_q && cmp_evt) |=> flags_q[1])
    else $error("compare flag missed a match");

  a_ovf_flag_sync: assert property (
    (!async_sel_q && ovf_evt) |=> flags_q[0])
    else $error("overflow flag missed an overflow");

  a_async_flag_delay: assert property (
    (async_sel_q && cmp_evt) ##1 async_sel_q [*3] |=> flags_q[1])
    else $error("async compare flag not set after sync delay");

  a_irq_request: assert property (
    (global_irq_enable_i && mask_q[1] && flags_q[1]) |-> compare_irq_o)
    else $error("compare irq not raised");

  a_busy_on_write: assert property (
    (async_sel_q && wr_vec[2]) |=> busy[2] [*1] ##0 !apply_vec[2])
    else $error("counter busy not set on async write");

  a_write_blocks: assert property (
    apply_vec[2] |=> (block_q && !cmp_evt))
    else $error("compare match not blocked after counter write");

  a_ctc_wrap: assert property (
    (tick && is_ctc && cnt_q == ocr_q && !apply_vec[2] && !apply_vec[0])
      |=> cnt_q == tmr_pkg::CNT_BOTTOM)
    else $error("clear-on-match did not clear counter");

  a_psr_selfclear: assert property (
    (psr_q && !async_sel_q && !sync_hold_q && !wr_shared) |=> !psr_q)
    else $error("prescaler reset bit did not self-clear");

endmodule
`default_nettype wire

// *** testbench/tmr_timer_bench.sv ***
// self-checking bench of the 8-bit compare timer
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin errors++; \
  $display("unexpected %s expected %0h seen %0h", nm, ex, got); end end
module async_8bit_timer_compare_pwm_bench;
  typedef struct packed {logic we; logic [7:0] adr; logic [7:0] dat; logic [7:0] ex;} tmr_row_t;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, gie = 0, cva = 0, ova = 0, osc = 0, dir = 0;
  logic [7:0] adr = 8'h00, q;
  logic [31:0] dat = 32'h0, dat_o;
  logic ack, cirq, oirq, pin, ovr, oe, bufen, xrun;
  int errors = 0, num_checks = 0, cyc_cnt = 0;
  tmr_row_t rows [0:12] = '{
    '{1'b1, 8'h08, 8'h5a, 8'h00}, '{1'b0, 8'h08, 8'h00, 8'h5a},
    '{1'b1, 8'h0c, 8'h03, 8'h00}, '{1'b0, 8'h0c, 8'h00, 8'h03},
    '{1'b1, 8'h04, 8'h33, 8'h00}, '{1'b0, 8'h04, 8'h00, 8'h33},
    '{1'b1, 8'h00, 8'h88, 8'h00}, '{1'b0, 8'h00, 8'h00, 8'h08},
    '{1'b0, 8'h1c, 8'h00, 8'h00},
    '{1'b1, 8'h18, 8'h82, 8'h00}, '{1'b0, 8'h18, 8'h00, 8'h82},
    '{1'b1, 8'h18, 8'h02, 8'h00}, '{1'b0, 8'h18, 8'h00, 8'h00}};
  always #4 clk_i = ~clk_i;
  tmr_timer dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .global_irq_enable_i(gie), .compare_vector_ack_i(cva), .overflow_vector_ack_i(ova),
    .compare_irq_o(cirq), .overflow_irq_o(oirq), .oscillator_input_pin_i(osc),
    .port_dir_i(dir), .compare_output_pin_o(pin), .compare_output_override_o(ovr),
    .compare_output_oe_o(oe), .ext_clock_buffer_en_o(bufen), .crystal_osc_run_o(xrun));
  // ----------------------------------------------------------------
  // bus cycles and closing
  // ----------------------------------------------------------------
  task automatic wb(input int w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= (w != 0); adr <= a; dat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = dat_o[7:0];
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (n >= 50) errors++;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] ex);
    wb(0, a, 8'h00);
    `CHK("read", ex, q)
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic rise();
    tick(4); osc <= 1'b1; tick(4); osc <= 1'b0;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      errors++;
      results();
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    tick(12); rst_i <= 1'b0; tick(1);
    foreach (rows[i]) begin
      if (rows[i].we) wb(1, rows[i].adr, rows[i].dat);
      else rd(rows[i].adr, rows[i].ex);
    end
    $display("test table done");
    // forced match: set, clear, toggle twice, no flag
    wb(1, 8'h00, 8'hb0); tick(2); `CHK("pin set", 1'b1, pin)
    dir <= 1'b1; tick(1); `CHK("oe", 1'b1, oe)
    `CHK("override", 1'b1, ovr)
    wb(1, 8'h00, 8'ha0); tick(2); `CHK("pin clr", 1'b0, pin)
    wb(1, 8'h00, 8'h90); tick(2); `CHK("pin tgl", 1'b1, pin)
    wb(1, 8'h00, 8'h90); tick(2); `CHK("pin tgl2", 1'b0, pin)
    rd(8'h10, 8'h00);
    wb(1, 8'h00, 8'h00); tick(1); `CHK("override off", 1'b0, ovr)
    $display("test force done");
    // compare flag, interrupt, vector clear
    wb(1, 8'h04, 8'h10); wb(1, 8'h08, 8'h12); wb(1, 8'h00, 8'h09);
    tick(6); wb(1, 8'h00, 8'h00);
    rd(8'h10, 8'h02);
    gie <= 1'b1; wb(1, 8'h0c, 8'h02); tick(1); `CHK("cmp irq", 1'b1, cirq)
    cva <= 1'b1; tick(1); cva <= 1'b0; tick(2); `CHK("cmp irq clr", 1'b0, cirq)
    rd(8'h10, 8'h00);
    $display("test compare done");
    // overflow flag and write-one clear
    wb(1, 8'h04, 8'hfe); wb(1, 8'h00, 8'h01); tick(4); wb(1, 8'h00, 8'h00);
    rd(8'h10, 8'h01);
    wb(1, 8'h0c, 8'h01); tick(1); `CHK("ovf irq", 1'b1, oirq)
    gie <= 1'b0; tick(2); `CHK("ovf irq gie", 1'b0, oirq)
    wb(1, 8'h10, 8'h01); rd(8'h10, 8'h00);
    $display("test overflow done");
    // fast pwm then phase-correct pwm, compare at 0x12
    wb(1, 8'h04, 8'h00); wb(1, 8'h00, 8'h69); tick(100); `CHK("fast lo", 1'b0, pin)
    tick(165); `CHK("fast hi", 1'b1, pin)
    rd(8'h10, 8'h03);
    wb(1, 8'h00, 8'h60); wb(1, 8'h04, 8'h00); wb(1, 8'h10, 8'h03); wb(1, 8'h00, 8'h61);
    tick(100); `CHK("pc up", 1'b0, pin)
    tick(200); rd(8'h10, 8'h02);
    tick(200); `CHK("pc down", 1'b1, pin)
    tick(10); rd(8'h10, 8'h03);
    wb(1, 8'h00, 8'h00); wb(1, 8'h10, 8'h03);
    $display("test pwm done");
    // asynchronous transfer with busy flag
    wb(1, 8'h14, 8'h08); tick(1); `CHK("crystal", 1'b1, xrun)
    `CHK("buffer", 1'b0, bufen)
    wb(1, 8'h04, 8'h40); rd(8'h14, 8'h0c);
    rise(); rise(); tick(3);
    rd(8'h14, 8'h08);
    rd(8'h04, 8'h40);
    wb(1, 8'h08, 8'h41); wb(1, 8'h00, 8'h01); rise(); rise();
    rise(); rise(); tick(6); rd(8'h10, 8'h02);
    wb(1, 8'h14, 8'h10); tick(1); `CHK("buffer sync", 1'b0, bufen)
    wb(1, 8'h14, 8'h18); tick(1); `CHK("buffer on", 1'b1, bufen)
    `CHK("crystal off", 1'b0, xrun)
    $display("test async done");
    // second reset in mid-run
    rst_i <= 1'b1; tick(2); rst_i <= 1'b0; tick(1);
    for (int a = 0; a < 8'h1c; a += 4) rd(8'(a), 8'h00);
    $display("test reset done");
    results();
  end
endmodule
`default_nettype wire
